// file: hdl/spp_port_ctrl.sv
// Strobed parallel port: data latch, control/status, strobes and flag pins
`timescale 1ns/1ps
`include "spp_params.svh"
module spp_port_ctrl #(
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    // CPU special function register access
    input  wire logic [7:0]          sfr_addr_i,
    input  wire logic                sfr_wr_i,
    input  wire logic                sfr_rd_i,
    input  wire spp_pkg::spp_byte_t  sfr_wdata_i,
    output spp_pkg::spp_byte_t       sfr_rdata_o,
    // Parallel port data pins
    input  wire spp_pkg::spp_byte_t  port_data_i,
    output spp_pkg::spp_byte_t       port_data_o,
    output logic                     port_data_oe_o,
    // Strobes
    input  wire logic                output_strobe_n_i,
    input  wire logic                input_strobe_n_i,
    // Flag pins
    input  wire logic                flag_pin_a_i,
    output logic                     flag_pin_a_o,
    output logic                     flag_pin_a_oe_o,
    input  wire logic                flag_pin_b_i,
    output logic                     flag_pin_b_o,
    output logic                     flag_pin_b_oe_o
);
    import spp_pkg::*;

    spp_state_t    s;
    spp_state_t    next_s;
    spp_pin_mode_t mode_a;
    spp_pin_mode_t mode_b;
    logic          pe_block;
    logic          ods_ev;
    logic          ids_ev;
    logic          wr_p6;
    logic          wr_csr;
    logic          rd_p6;
    logic          rd_csr;
    logic          out_always;
    logic          load;
    logic          cap_valid;
    spp_byte_t     cap_data;
    logic          drn_ready;

    spp_stream_if #(.WIDTH(8)) cap_if ();
    spp_stream_if #(.WIDTH(8)) drn_if ();

    assign cap_if.valid = cap_valid;
    assign cap_if.data = cap_data;
    assign drn_if.ready = drn_ready;

    spp_skid_buf #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .in_s     (cap_if),
        .out_s    (drn_if)
    );

    function automatic logic spp_rise(input logic [2:0] v);
        return v[1] && !v[2];
    endfunction : spp_rise

    function automatic logic spp_fall(input logic [2:0] v);
        return !v[1] && v[2];
    endfunction : spp_fall

    always_comb begin
        next_s = s;
        // Bit 0 is the first synchroniser stage, read only by bit 1
        next_s.ods_sync = {s.ods_sync[1:0], output_strobe_n_i};
        next_s.ids_sync = {s.ids_sync[1:0], input_strobe_n_i};
        next_s.a_sync = {s.a_sync[1:0], flag_pin_a_i};
        next_s.b_sync = {s.b_sync[1:0], flag_pin_b_i};
        next_s.pd_s1 = port_data_i;
        next_s.pd_s2 = s.pd_s1;

        mode_a = spp_pin_mode_t'(s.port6_ctrl_status[`SPP_A_HI:`SPP_A_LO]);
        mode_b = spp_pin_mode_t'(s.port6_ctrl_status[`SPP_B_HI:`SPP_B_LO]);
        pe_block = (mode_b == SPP_PIN_INPUT) && s.b_sync[1];
        ods_ev = !pe_block && (s.port6_ctrl_status[`SPP_OCLR_SEL] ? spp_rise(s.ods_sync)
                                                    : spp_fall(s.ods_sync));
        ids_ev = !pe_block && (s.port6_ctrl_status[`SPP_IN_MODE] ? spp_fall(s.ids_sync)
                                                   : spp_rise(s.ids_sync));
        wr_p6 = sfr_wr_i && (sfr_addr_i == `SPP_P6_ADDR);
        wr_csr = sfr_wr_i && (sfr_addr_i == `SPP_CSR_ADDR);
        rd_p6 = sfr_rd_i && (sfr_addr_i == `SPP_P6_ADDR);
        rd_csr = sfr_rd_i && (sfr_addr_i == `SPP_CSR_ADDR);

        // CPU writes; flag bits stay read-only
        if (wr_p6) begin
            next_s.p6 = sfr_wdata_i;
        end
        if (wr_csr) begin
            next_s.port6_ctrl_status[7:`SPP_RW_LO] = sfr_wdata_i[7:`SPP_RW_LO];
        end

        // Output full: a write in the same cycle as a clear edge wins
        if (wr_p6) begin
            next_s.port6_ctrl_status[`SPP_OBF] = 1'b1;
        end else if (ods_ev) begin
            next_s.port6_ctrl_status[`SPP_OBF] = 1'b0;
        end

        // Capture into the buffer; a refused word waits as pending
        cap_valid = ids_ev || s.pend;
        cap_data = ids_ev ? s.pd_s2 : s.pend_data;
        next_s.pend = cap_valid && !cap_if.ready;
        if (cap_valid && !cap_if.ready) begin
            next_s.pend_data = cap_data;
        end

        // Transparent input register follows the pins until strobe rises
        if (s.transp) begin
            next_s.in_reg = s.pd_s2;
            if (spp_rise(s.ids_sync) || !s.port6_ctrl_status[`SPP_IN_MODE] || pe_block) begin
                next_s.transp = 1'b0;
            end
        end

        // Input full: load from buffer in the same cycle as a read wins
        drn_ready = !s.port6_ctrl_status[`SPP_IBF] || rd_p6;
        load = drn_if.valid && drn_ready;
        if (rd_p6) begin
            next_s.port6_ctrl_status[`SPP_IBF] = 1'b0;
        end
        if (load) begin
            next_s.in_reg = drn_if.data;
            next_s.port6_ctrl_status[`SPP_IBF] = 1'b1;
            next_s.transp = s.port6_ctrl_status[`SPP_IN_MODE] && !s.ids_sync[1] && !pe_block;
        end

        // Read data
        if (rd_p6) begin
            next_s.rdata = s.in_reg;
        end else if (rd_csr) begin
            next_s.rdata = s.port6_ctrl_status;
        end else if (sfr_rd_i) begin
            next_s.rdata = 8'h00;
        end

        // Port drivers and data source
        out_always = !s.port6_ctrl_status[`SPP_B_HI] && (mode_a == SPP_PIN_FLAG);
        next_s.pout = ((mode_a == SPP_PIN_INPUT) && s.a_sync[1]) ? s.port6_ctrl_status : s.p6;
        next_s.poe = out_always || (!pe_block && !s.ods_sync[1]);

        // Flag pins follow the mode and flags as they will be next cycle
        unique case (spp_pin_mode_t'(next_s.port6_ctrl_status[`SPP_A_HI:`SPP_A_LO]))
            SPP_PIN_LOW:   {next_s.a_o, next_s.a_oe} = 2'h1;
            SPP_PIN_HIGH:  {next_s.a_o, next_s.a_oe} = 2'h3;
            SPP_PIN_FLAG:  {next_s.a_o, next_s.a_oe} = {next_s.port6_ctrl_status[`SPP_OBF], 1'b1};
            SPP_PIN_INPUT: {next_s.a_o, next_s.a_oe} = 2'h0;
        endcase
        unique case (spp_pin_mode_t'(next_s.port6_ctrl_status[`SPP_B_HI:`SPP_B_LO]))
            SPP_PIN_LOW:   {next_s.b_o, next_s.b_oe} = 2'h1;
            SPP_PIN_HIGH:  {next_s.b_o, next_s.b_oe} = 2'h3;
            SPP_PIN_FLAG:  {next_s.b_o, next_s.b_oe} = {next_s.port6_ctrl_status[`SPP_IBF], 1'b1};
            SPP_PIN_INPUT: {next_s.b_o, next_s.b_oe} = 2'h0;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
            s.p6 <= `SPP_P6_RST;
            s.port6_ctrl_status <= `SPP_CSR_RST;
            s.pout <= `SPP_P6_RST;
            s.ods_sync <= `SPP_SYNC_RST_N;
            s.ids_sync <= `SPP_SYNC_RST_N;
            s.a_sync <= `SPP_SYNC_RST;
            s.b_sync <= `SPP_SYNC_RST;
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata_o = s.rdata;
    assign port_data_o = s.pout;
    assign port_data_oe_o = s.poe;
    assign flag_pin_a_o = s.a_o;
    assign flag_pin_a_oe_o = s.a_oe;
    assign flag_pin_b_o = s.b_o;
    assign flag_pin_b_oe_o = s.b_oe;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence seq_push_into_empty;
        cap_valid && cap_if.ready && !drn_if.valid && !s.port6_ctrl_status[`SPP_IBF];
    endsequence

    sequence seq_loaded;
        s.port6_ctrl_status[`SPP_IBF] && (s.in_reg == $past(cap_data, 2));
    endsequence

    AST_OBF_CLR_RISE: assert property (s.port6_ctrl_status[3] && !pe_block && !wr_p6
        && s.ods_sync[1] && !s.ods_sync[2] |=> !s.port6_ctrl_status[1])
        else $error("output full not cleared on strobe rise");
    AST_OBF_CLR_FALL: assert property (!s.port6_ctrl_status[3] && !pe_block && !wr_p6
        && !s.ods_sync[1] && s.ods_sync[2] |=> !s.port6_ctrl_status[1])
        else $error("output full not cleared on strobe fall");
    AST_A_CONST: assert property (s.port6_ctrl_status[5] == 1'b0 |-> s.a_oe && (s.a_o == s.port6_ctrl_status[4]))
        else $error("A pin constant output wrong");
    AST_A_FLAG: assert property (s.port6_ctrl_status[5:4] == 2'h2 |-> s.a_oe && (s.a_o == s.port6_ctrl_status[1]))
        else $error("A pin does not follow output full");
    AST_A_SELECT: assert property (s.port6_ctrl_status[5:4] == 2'h3 && s.a_sync[1] && !wr_csr
        |=> !s.a_oe && (s.pout == $past(s.port6_ctrl_status)))
        else $error("A select does not send control/status");
    AST_B_MODES: assert property (s.port6_ctrl_status[7:6] != 2'h3 |-> s.b_oe
        && (s.b_o == (s.port6_ctrl_status[7] ? s.port6_ctrl_status[0] : s.port6_ctrl_status[6])))
        else $error("B pin output wrong");
    AST_PE_FLOAT: assert property (pe_block |=> !s.poe)
        else $error("port driven while B disables it");
    AST_PE_NO_CAPTURE: assert property (pe_block && !s.pend |-> !cap_valid)
        else $error("strobe taken while port disabled");
    AST_IBF_LOAD: assert property (seq_push_into_empty ##2 1'b1 |-> seq_loaded)
        else $error("captured byte not loaded with input full");
    AST_OBF_SET: assert property (wr_p6 |=> s.port6_ctrl_status[1] && (s.p6 == $past(sfr_wdata_i)))
        else $error("latch write did not set output full");
    AST_CSR_WRITE: assert property (wr_csr
        |=> (s.port6_ctrl_status[7:2] == $past(sfr_wdata_i[7:2]))
        && (!s.port6_ctrl_status[1] || $past(s.port6_ctrl_status[1]) || $past(wr_p6))
        && (!s.port6_ctrl_status[0] || $past(s.port6_ctrl_status[0]) || $past(drn_if.valid)))
        else $error("control write wrong");
    AST_IBF_CLR: assert property (rd_p6 && !drn_if.valid |=> !s.port6_ctrl_status[0])
        else $error("input read did not clear input full");
    AST_P6_READ: assert property (rd_p6 |=> sfr_rdata_o == $past(s.in_reg))
        else $error("port read returned wrong byte");
endmodule : spp_port_ctrl

// file: hdl/spp_params.svh
// Offsets, field positions, reset values of the strobed parallel port
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_P6_ADDR    8'hd8
`define SPP_CSR_ADDR   8'he8
`define SPP_P6_RST     8'hff
`define SPP_CSR_RST    8'hfc
`define SPP_IBF        0
`define SPP_OBF        1
`define SPP_IN_MODE    2
`define SPP_OCLR_SEL   3
`define SPP_A_LO       4
`define SPP_A_HI       5
`define SPP_B_LO       6
`define SPP_B_HI       7
`define SPP_RW_LO      2
`define SPP_SYNC_RST_N 3'h7
`define SPP_SYNC_RST   3'h0

`endif

// file: hdl/spp_pkg.sv
// Types of the strobed parallel port
package spp_pkg;
    typedef logic [7:0] spp_byte_t;

    // Flag pin mode, order follows the two mode bits
    typedef enum logic [1:0] {
        SPP_PIN_LOW,
        SPP_PIN_HIGH,
        SPP_PIN_FLAG,
        SPP_PIN_INPUT
    } spp_pin_mode_t;

    typedef struct packed {
        spp_byte_t  p6;
        spp_byte_t  port6_ctrl_status;
        logic [2:0] ods_sync;
        logic [2:0] ids_sync;
        logic [2:0] a_sync;
        logic [2:0] b_sync;
        spp_byte_t  pd_s1;
        spp_byte_t  pd_s2;
        spp_byte_t  in_reg;
        logic       transp;
        logic       pend;
        spp_byte_t  pend_data;
        spp_byte_t  rdata;
        spp_byte_t  pout;
        logic       poe;
        logic       a_o;
        logic       a_oe;
        logic       b_o;
        logic       b_oe;
    } spp_state_t;
endpackage : spp_pkg

// file: hdl/spp_stream_if.sv
// Valid/ready byte stream between the port logic and its buffer
`timescale 1ns/1ps
interface spp_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : spp_stream_if

// file: hdl/spp_skid_buf.sv
// Small FIFO between strobe capture and the input buffer register
`timescale 1ns/1ps
module spp_skid_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic    clk_i,
    input wire logic    arst_n_i,
    // Streams
    spp_stream_if.snk   in_s,
    spp_stream_if.src   out_s
);
    import spp_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } spp_fifo_state_t;

    spp_fifo_state_t s;
    spp_fifo_state_t next_s;
    logic            push;
    logic            pop;

    function automatic logic [AW-1:0] spp_wrap(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : spp_wrap

    assign in_s.ready = (s.cnt != (AW+1)'(DEPTH));
    assign out_s.valid = (s.cnt != '0);
    assign out_s.data = s.mem[s.rp];

    always_comb begin
        next_s = s;
        push = in_s.valid && in_s.ready;
        pop = out_s.valid && out_s.ready;
        if (push) begin
            next_s.mem[s.wp] = in_s.data;
            next_s.wp = spp_wrap(s.wp);
        end
        if (pop) begin
            next_s.rp = spp_wrap(s.rp);
        end
        next_s.cnt = (AW+1)'(s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    AST_BUF_FULL_HOLDS: assert property (!in_s.ready && !out_s.ready |=> !in_s.ready)
        else $error("buffer lost its full state without a pop");
endmodule : spp_skid_buf

// file: verif/spp_host_model.sv
// Host model at the far side of the parallel port: strobes, flag inputs, data
`timescale 1ns/1ps
module spp_host_model (
    // Clock
    input  wire logic       clk_i,
    // Pins driven by the host
    output logic            ods_n_o,
    output logic            ids_n_o,
    output logic            a_o,
    output logic            b_o,
    output logic [7:0]      data_o
);
    logic drv = 1'b0;

    initial begin
        ods_n_o = 1'b1;
        ids_n_o = 1'b1;
        a_o     = 1'b0;
        b_o     = 1'b0;
        data_o  = 8'h5a;
    end

    // Released bus shows a changing pattern
    always @(posedge clk_i) begin
        if (!drv) begin
            data_o <= ~data_o;
        end
    end

    task automatic pins(input logic a, input logic b);
        @(posedge clk_i);
        a_o <= a;
        b_o <= b;
        repeat (6) @(posedge clk_i);
    endtask : pins

    task automatic output_strobe_n(input logic v);
        @(posedge clk_i);
        ods_n_o <= v;
        repeat (5) @(posedge clk_i);
    endtask : output_strobe_n

    // One byte per input strobe, each level held several cycles
    task automatic send(input logic [7:0] d);
        @(posedge clk_i);
        drv <= 1'b1;
        @(posedge clk_i);
        data_o <= d;
        repeat (2) @(posedge clk_i);
        ids_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        ids_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        drv <= 1'b0;
    endtask : send
endmodule : spp_host_model

// file: verif/tb_top.sv
// Self-checking bench of the strobed parallel port
`timescale 1ns/1ps
module tb_top;
    import spp_pkg::*;
    logic       clk_i;
    logic       arst_n_i;
    logic [7:0] addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic       rd_q     = 1'b0;
    spp_byte_t  wdat;
    spp_byte_t  rdat;
    spp_byte_t  pdo;
    spp_byte_t  hdat;
    spp_byte_t  pwire;
    spp_byte_t  r;
    spp_byte_t  rq[3];
    logic       poe, ods_n, ids_n, ha, hb, ao, aoe, bo, boe, aw, bw;
    int         miscompares = 0;
    int         checks = 0;
    spp_byte_t  exp_q[$];

    assign aw    = aoe ? ao : ha;
    assign bw    = boe ? bo : hb;
    assign pwire = poe ? pdo : hdat;

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    spp_port_ctrl dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i),
        .sfr_addr_i(addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_wdata_i(wdat), .sfr_rdata_o(rdat),
        .port_data_i(pwire), .port_data_o(pdo), .port_data_oe_o(poe),
        .output_strobe_n_i(ods_n), .input_strobe_n_i(ids_n),
        .flag_pin_a_i(aw), .flag_pin_a_o(ao), .flag_pin_a_oe_o(aoe),
        .flag_pin_b_i(bw), .flag_pin_b_o(bo), .flag_pin_b_oe_o(boe)
    );

    spp_host_model host (
        .clk_i(clk_i), .ods_n_o(ods_n), .ids_n_o(ids_n),
        .a_o(ha), .b_o(hb), .data_o(hdat)
    );

    task automatic check(input spp_byte_t seen, input spp_byte_t exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask : w

    task automatic wr(input logic [7:0] a, input spp_byte_t d);
        @(posedge clk_i);
        addr   <= a;
        wdat   <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_i);
        sfr_wr <= 1'b0;
        w(2);
    endtask : wr

    task automatic rd(input logic [7:0] a, input spp_byte_t exp);
        @(posedge clk_i);
        exp_q.push_back(exp);
        addr   <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_i);
        sfr_rd <= 1'b0;
        w(2);
    endtask : rd

    // Read data lands one cycle after the read pulse
    always @(posedge clk_i) rd_q <= sfr_rd;
    always @(negedge clk_i) begin
        if (rd_q && exp_q.size() > 0) begin
            check(rdat, exp_q.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        report_and_stop;
    end

    initial begin
        arst_n_i <= 1'b0;
        addr     <= 8'h00;
        sfr_wr   <= 1'b0;
        sfr_rd   <= 1'b0;
        wdat     <= 8'h00;
        void'($urandom(59548));
        w(20);
        arst_n_i <= 1'b1;
        w(2);
        check(pdo, 8'hff);
        check({6'h0, aoe, boe}, 8'h00);
        rd(8'he8, 8'hfc);
        wr(8'he8, 8'hff);
        rd(8'he8, 8'hfc);
        rd(8'h55, 8'h00);
        // Constant drive modes of both flag pins
        for (int m = 0; m < 2; m++) begin
            wr(8'he8, m ? 8'h50 : 8'h00);
            check({6'h0, ao, aoe}, {6'h0, m[0], 1'b1});
            check({6'h0, bo, boe}, {6'h0, m[0], 1'b1});
        end
        // Output full flag cleared by falling, then by rising strobe edge
        wr(8'he8, 8'ha0);
        r = spp_byte_t'($urandom);
        wr(8'hd8, r);
        check({7'h0, ao}, 8'h01);
        rd(8'he8, 8'ha2);
        host.output_strobe_n(1'b0);
        check({7'h0, ao}, 8'h00);
        check({7'h0, poe}, 8'h01);
        check(pdo, r);
        host.output_strobe_n(1'b1);
        wr(8'he8, 8'ha8);
        wr(8'hd8, ~r);
        host.output_strobe_n(1'b0);
        check({7'h0, ao}, 8'h01);
        host.output_strobe_n(1'b1);
        check({7'h0, ao}, 8'h00);
        // Input capture in both strobe modes
        for (int k = 0; k < 2; k++) begin
            wr(8'he8, k ? 8'ha4 : 8'ha0);
            r = spp_byte_t'($urandom);
            host.send(r);
            w(4);
            check({7'h0, bo}, 8'h01);
            rd(8'hd8, r);
            check({7'h0, bo}, 8'h00);
        end
        // Source select through the A pin
        wr(8'he8, 8'h30);
        r = spp_byte_t'($urandom);
        wr(8'hd8, r);
        host.pins(1'b0, 1'b0);
        check(pdo, r);
        host.pins(1'b1, 1'b0);
        check(pdo, 8'h32);
        // Port enable through the B pin
        wr(8'he8, 8'hc0);
        host.pins(1'b0, 1'b1);
        host.send(8'h3c);
        w(4);
        rd(8'he8, 8'hc2);
        host.output_strobe_n(1'b0);
        check({7'h0, poe}, 8'h00);
        host.output_strobe_n(1'b1);
        rd(8'he8, 8'hc2);
        host.pins(1'b0, 1'b0);
        // Three bytes without a read fill the buffer behind the input register
        for (int j = 0; j < 3; j++) begin
            rq[j] = spp_byte_t'($urandom);
            host.send(rq[j]);
        end
        w(4);
        rd(8'he8, 8'hc3);
        for (int j = 0; j < 3; j++) begin
            rd(8'hd8, rq[j]);
        end
        rd(8'he8, 8'hc2);
        w(4);
        report_and_stop;
    end
endmodule : tb_top
